// ==== vdp_pkg.sv ====
// Shared constants and types of the video decode post-processor.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package vdp_pkg;
    localparam int NUM_PATHS = 3;
    localparam int DW = 14;
    localparam int SW = 10;
    localparam int REDUCE_SHIFT = 2;

    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_PIC       = 8'h08;
    localparam logic [7:0] OFF_PATH_BASE = 8'h10;
    localparam logic [7:0] OFF_PATH_STEP = 8'h10;
    // Word index of each register inside a path block
    localparam logic [1:0] R_CFG = 2'h0;
    localparam logic [1:0] R_TWH = 2'h1;
    localparam logic [1:0] R_TXY = 2'h2;
    localparam logic [1:0] R_RSZ = 2'h3;

    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CTRL_HWRET = 2;
    localparam int CTRL_GANG  = 3;
    localparam int CTRL_JPEG  = 4;
    localparam int CTRL_SRC10 = 5;
    localparam int ST_ACTIVE  = 0;
    localparam int ST_DIMERR  = 1;
    localparam int ST_JPGERR  = 2;
    localparam int ST_FRAMES  = 16;
    localparam int PC_EN      = 0;
    localparam int PC_LAY     = 1;
    localparam int PC_REDUCE  = 3;
    localparam int PC_MANUAL  = 4;
    localparam int F_W        = 0;
    localparam int F_H        = 16;

    localparam logic [DW-1:0] MIN_DIM      = 14'd144;
    localparam logic [DW-1:0] MIN_DIM_JPEG = 14'd48;
    localparam logic [DW-1:0] MAX_DIM      = 14'd8192;
    localparam logic [2:0]    CORES_SINGLE = 3'h1;
    localparam logic [2:0]    CORES_GANG   = 3'h4;

    // Metadata payload type numbers that are returned
    localparam logic [7:0] SEI_BUF_PERIOD = 8'h00;
    localparam logic [7:0] SEI_PIC_TIMING = 8'h01;
    localparam logic [7:0] SEI_T35        = 8'h04;
    localparam logic [7:0] SEI_MASTERING  = 8'h89;
    localparam logic [7:0] SEI_LIGHT_LVL  = 8'h90;
    localparam logic [7:0] SEI_ALT_XFER   = 8'h93;

    typedef enum logic [1:0] {LAY_PLANAR, LAY_SEMI, LAY_TILED}
        vdp_layout_type;
    typedef enum logic {PH_IDLE, PH_ACTIVE} vdp_phase_type;

    typedef struct packed {
        logic           en;
        vdp_layout_type layout;
        logic           reduce;
        logic           manual;
        logic [DW-1:0]  tw;
        logic [DW-1:0]  th;
        logic [DW-1:0]  tx;
        logic [DW-1:0]  ty;
        logic [DW-1:0]  rw;
        logic [DW-1:0]  rh;
    } vdp_pcfg_type;

    typedef struct packed {
        logic          out_valid;
        logic [SW-1:0] out_data;
        logic [DW:0]   accx;
        logic [DW:0]   accy;
    } vdp_pstate_type;
endpackage

// ==== vdp_path_if.sv ====
// Carrier between the top and one post-processing path.
// Assumes config is stable while a session runs.
`timescale 1ns/1ps
`default_nettype none
interface vdp_path_if;
    import vdp_pkg::*;
    vdp_pcfg_type  cfg;
    logic [DW-1:0] x;
    logic [DW-1:0] y;
    logic          in_valid;
    logic          in_ready;
    logic [SW-1:0] in_data;
    logic          in_eol;
    logic          in_eof;
    logic          out_valid;
    logic          out_ready;
    logic [SW-1:0] out_data;
    modport top  (output cfg, x, y, in_valid, in_data, in_eol, in_eof,
                  out_ready, input in_ready, out_valid, out_data);
    modport proc (input cfg, x, y, in_valid, in_data, in_eol, in_eof,
                  out_ready, output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// ==== vdp_path_proc.sv ====
// One post-processing path: crop window, decimating scaler, depth cut.
// Assumes in_valid means the sample is taken this cycle.
`timescale 1ns/1ps
`default_nettype none
module vdp_path_proc
    import vdp_pkg::*;
(
    input wire logic   clock,
    input wire logic   nrst,
    vdp_path_if.proc   pif
);
    vdp_pstate_type s_r;
    vdp_pstate_type s_nxt;
    logic [DW:0]    xe;
    logic [DW:0]    ye;
    logic [DW:0]    ax;
    logic [DW:0]    ay;
    logic           row_in;
    logic           in_win;
    logic           keep;

    assign pif.in_ready  = !s_r.out_valid || pif.out_ready;
    assign pif.out_valid = s_r.out_valid;
    assign pif.out_data  = s_r.out_data;

    always_comb begin
        xe = {1'b0, pif.cfg.tx} + {1'b0, pif.cfg.tw};
        ye = {1'b0, pif.cfg.ty} + {1'b0, pif.cfg.th};
        ax = s_r.accx + {1'b0, pif.cfg.rw};
        ay = s_r.accy + {1'b0, pif.cfg.rh};
        row_in = pif.y >= pif.cfg.ty && {1'b0, pif.y} < ye;
        // Crop decides first, the scaler only sees window samples
        in_win = pif.cfg.en && row_in && pif.x >= pif.cfg.tx
                 && {1'b0, pif.x} < xe;
        keep = in_win && ax >= {1'b0, pif.cfg.tw}
               && ay >= {1'b0, pif.cfg.th};
        s_nxt = s_r;
        if (pif.out_ready) begin
            s_nxt.out_valid = 1'b0;
        end
        if (pif.in_valid) begin
            if (keep) begin
                s_nxt.out_valid = 1'b1;
                s_nxt.out_data = pif.cfg.reduce ?
                    {{REDUCE_SHIFT{1'b0}}, pif.in_data[SW-1:REDUCE_SHIFT]}
                    : pif.in_data;
            end
            if (in_win) begin
                s_nxt.accx = (ax >= {1'b0, pif.cfg.tw}) ?
                    ax - {1'b0, pif.cfg.tw} : ax;
            end
            if (pif.in_eol) begin
                s_nxt.accx = '0;
                if (row_in) begin
                    s_nxt.accy = (ay >= {1'b0, pif.cfg.th}) ?
                        ay - {1'b0, pif.cfg.th} : ay;
                end
            end
            if (pif.in_eof) begin
                s_nxt.accx = '0;
                s_nxt.accy = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    depth_cut_a: assert property (@(posedge clock) disable iff (!nrst)
        pif.in_valid && keep && pif.cfg.reduce |=>
        pif.out_valid && pif.out_data[SW-1:SW-REDUCE_SHIFT] == '0
        && pif.out_data == ($past(pif.in_data) >> REDUCE_SHIFT))
        else $error("depth reduction wrong");
    crop_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        pif.in_valid && !in_win && !(s_r.out_valid && !pif.out_ready)
        |=> !pif.out_valid)
        else $error("sample outside crop window emitted");
endmodule
`default_nettype wire

// ==== vdp_top.sv ====
// Contract
// - Three paths; path 0 always on, paths 1 and 2 enabled, default off.
// - In each path cropping happens before scaling.
// - Picture size 144..8192 square range; JPEG allows 48 minimum.
// - Software return sends path 0 samples to host; paths 1, 2 off.
// - Hardware return keeps pixels on chip, one handle per enabled path.
// - Enabled paths 1 and 2 always deliver hardware frame handles.
// - Depth reduce shifts 10-bit samples right by 2; not JPEG, tiled.
// - Layout 0 planar, 1 semiplanar by depth, 2 tiled; default 0.
// - Crop source auto uses header window, manual uses programmed one.
// - Manual crop takes programmed window; default full picture at 0.
// - Crop offsets beyond the picture are pulled back to fit.
// - Scale to programmed size if given, else pass unscaled; no upsize.
// - One core by default; ganged mode uses all four cores.
// - JPEG decodes 8-bit baseline only.
// - Supported metadata payloads are returned to the host.
// Top of the post-processor: Avalon-MM slave, session capture, path fan-out.
// Assumes pixel, header and metadata inputs come from this clock domain.
`timescale 1ns/1ps
`default_nettype none
module vdp_top
    import vdp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output var  logic [31:0]           readdata,
    output var  logic                  waitrequest,
    input  wire logic [4*DW-1:0]       hdr_trim,
    input  wire logic                  pix_valid,
    output var  logic                  pix_ready,
    input  wire logic [SW-1:0]         pix_data,
    input  wire logic                  pix_eol,
    input  wire logic                  pix_eof,
    output var  logic                  host_valid,
    input  wire logic                  host_ready,
    output var  logic [SW-1:0]         host_data,
    output var  logic [NUM_PATHS-1:0]  chip_valid,
    input  wire logic [NUM_PATHS-1:0]  chip_ready,
    output var  logic [NUM_PATHS*SW-1:0] chip_data,
    output var  logic                  handle_valid,
    output var  logic [NUM_PATHS-1:0]  handle_mask,
    output var  logic [NUM_PATHS-1:0]  handle_10bit,
    output var  logic [15:0]           handle_seq,
    output var  logic [2:0]            cores_used,
    input  wire logic                  sei_in_valid,
    input  wire logic [7:0]            sei_in_type,
    input  wire logic [31:0]           sei_in_data,
    output var  logic                  sei_out_valid,
    output var  logic [7:0]            sei_out_type,
    output var  logic [31:0]           sei_out_data
);
    typedef struct packed {
        vdp_phase_type                    phase;
        logic                             ack;
        logic [31:0]                      rdata;
        logic [5:0]                       ctrl;
        logic [31:0]                      pic;
        logic [NUM_PATHS-1:0][3:0][31:0]  preg;
        vdp_pcfg_type [NUM_PATHS-1:0]     cur;
        logic                             hw;
        logic                             gang;
        logic                             jpeg;
        logic                             src10;
        logic                             dim_err;
        logic                             jpg_err;
        logic [DW-1:0]                    x;
        logic [DW-1:0]                    y;
        logic [15:0]                      frames;
        logic                             hv;
        logic [NUM_PATHS-1:0]             hmask;
        logic [NUM_PATHS-1:0]             h10;
        logic                             sv;
        logic [7:0]                       stype;
        logic [31:0]                      sdata;
    } vdp_top_state_type;

    vdp_top_state_type    s_r;
    vdp_top_state_type    s_nxt;
    logic [NUM_PATHS-1:0] prdy;
    logic                 take;
    logic [DW-1:0]        pw;
    logic [DW-1:0]        ph;
    logic [DW-1:0]        lo;
    logic [3:0]           blk;
    logic                 ok_dim;

    vdp_path_if pif[NUM_PATHS] ();

    // Resolve one path's programmed words into the working window
    function automatic vdp_pcfg_type resolve(
        input logic [3:0][31:0] r,
        input logic [DW-1:0]    w0,
        input logic [DW-1:0]    h0,
        input logic [4*DW-1:0]  hdr,
        input logic             src10,
        input logic             jpeg,
        input logic             hw,
        input logic             first
    );
        vdp_pcfg_type c;
        logic [1:0]   lay;
        logic [DW:0]  sx;
        logic [DW:0]  sy;
        c = '0;
        lay = r[R_CFG][PC_LAY +: 2];
        c.en = first || (hw && r[R_CFG][PC_EN]);
        c.layout = (lay == 2'h3) ? LAY_PLANAR
                                 : vdp_layout_type'(lay);
        c.manual = r[R_CFG][PC_MANUAL];
        c.reduce = r[R_CFG][PC_REDUCE] && src10 && !jpeg
                   && c.layout != LAY_TILED;
        if (c.manual) begin
            c.tw = r[R_TWH][F_W +: DW];
            c.th = r[R_TWH][F_H +: DW];
            c.tx = r[R_TXY][F_W +: DW];
            c.ty = r[R_TXY][F_H +: DW];
        end else begin
            {c.ty, c.tx, c.th, c.tw} = hdr;
        end
        // Zero width means full picture, so reset values give full frame
        if (c.tw == '0 || c.tw > w0) c.tw = w0;
        if (c.th == '0 || c.th > h0) c.th = h0;
        sx = {1'b0, c.tx} + {1'b0, c.tw};
        sy = {1'b0, c.ty} + {1'b0, c.th};
        if (sx > {1'b0, w0}) c.tx = w0 - c.tw;
        if (sy > {1'b0, h0}) c.ty = h0 - c.th;
        c.rw = r[R_RSZ][F_W +: DW];
        c.rh = r[R_RSZ][F_H +: DW];
        if (c.rw == '0 || c.rw > c.tw) c.rw = c.tw;
        if (c.rh == '0 || c.rh > c.th) c.rh = c.th;
        return c;
    endfunction

    function automatic logic sei_ok(input logic [7:0] t);
        return t == SEI_BUF_PERIOD || t == SEI_PIC_TIMING || t == SEI_T35
            || t == SEI_MASTERING || t == SEI_LIGHT_LVL
            || t == SEI_ALT_XFER;
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PATHS; gp++) begin : g_path
            assign pif[gp].cfg      = s_r.cur[gp];
            assign pif[gp].x        = s_r.x;
            assign pif[gp].y        = s_r.y;
            assign pif[gp].in_valid = take;
            assign pif[gp].in_data  = pix_data;
            assign pif[gp].in_eol   = pix_eol;
            assign pif[gp].in_eof   = pix_eof;
            assign prdy[gp]         = pif[gp].in_ready;
            assign chip_data[gp*SW +: SW] = pif[gp].out_data;
            if (gp == 0) begin : g_p0
                // Path 0 goes to the host only for software return
                assign chip_valid[gp] = pif[gp].out_valid && s_r.hw;
                assign pif[gp].out_ready = s_r.hw ? chip_ready[gp]
                                                  : host_ready;
            end else begin : g_pn
                assign chip_valid[gp] = pif[gp].out_valid;
                assign pif[gp].out_ready = chip_ready[gp];
            end
            vdp_path_proc u_proc (
                .clock (clock),
                .nrst  (nrst),
                .pif   (pif[gp])
            );
        end
    endgenerate

    assign host_valid   = pif[0].out_valid && !s_r.hw;
    assign host_data    = pif[0].out_data;
    assign take         = pix_valid && pix_ready;
    assign pix_ready    = s_r.phase == PH_ACTIVE && &prdy;
    assign waitrequest  = (read || write) && !s_r.ack;
    assign readdata     = s_r.rdata;
    assign handle_valid = s_r.hv;
    assign handle_mask  = s_r.hmask;
    assign handle_10bit = s_r.h10;
    assign handle_seq   = s_r.frames;
    assign cores_used   = s_r.gang ? CORES_GANG : CORES_SINGLE;
    assign sei_out_valid = s_r.sv;
    assign sei_out_type  = s_r.stype;
    assign sei_out_data  = s_r.sdata;

    always_comb begin
        s_nxt = s_r;
        pw = s_r.pic[F_W +: DW];
        ph = s_r.pic[F_H +: DW];
        lo = writedata[CTRL_JPEG] ? MIN_DIM_JPEG : MIN_DIM;
        ok_dim = pw >= lo && ph >= lo && pw <= MAX_DIM
                 && ph <= MAX_DIM;
        blk = address[7:4] - OFF_PATH_BASE[7:4];
        s_nxt.ack = (read || write) && !s_r.ack;
        s_nxt.hv = 1'b0;
        s_nxt.sv = 1'b0;
        if (read && !s_r.ack) begin
            s_nxt.rdata = '0;
            if (address == OFF_CTRL) begin
                s_nxt.rdata[5:0] = s_r.ctrl;
            end else if (address == OFF_STATUS) begin
                s_nxt.rdata[ST_ACTIVE] = s_r.phase == PH_ACTIVE;
                s_nxt.rdata[ST_DIMERR] = s_r.dim_err;
                s_nxt.rdata[ST_JPGERR] = s_r.jpg_err;
                s_nxt.rdata[ST_FRAMES +: 16] = s_r.frames;
            end else if (address == OFF_PIC) begin
                s_nxt.rdata = s_r.pic;
            end else if (address >= OFF_PATH_BASE && address[1:0] == 2'h0
                         && blk < 4'(NUM_PATHS)) begin
                s_nxt.rdata = s_r.preg[blk[1:0]][address[3:2]];
            end
        end
        if (write && s_r.ack) begin
            if (address == OFF_CTRL) begin
                s_nxt.ctrl = writedata[5:0] & 6'h3C;
                if (writedata[CTRL_STOP]) begin
                    s_nxt.phase = PH_IDLE;
                end else if (writedata[CTRL_START]
                             && s_r.phase == PH_IDLE) begin
                    s_nxt.dim_err = !ok_dim;
                    s_nxt.jpg_err = writedata[CTRL_JPEG]
                                    && writedata[CTRL_SRC10];
                    if (ok_dim && !s_nxt.jpg_err) begin
                        // Settings frozen here for the session
                        s_nxt.phase = PH_ACTIVE;
                        s_nxt.hw    = writedata[CTRL_HWRET];
                        s_nxt.gang  = writedata[CTRL_GANG];
                        s_nxt.jpeg  = writedata[CTRL_JPEG];
                        s_nxt.src10 = writedata[CTRL_SRC10];
                        s_nxt.x = '0;
                        s_nxt.y = '0;
                        for (int p = 0; p < NUM_PATHS; p++) begin
                            s_nxt.cur[p] = resolve(s_r.preg[p], pw, ph,
                                hdr_trim, writedata[CTRL_SRC10],
                                writedata[CTRL_JPEG],
                                writedata[CTRL_HWRET], p == 0);
                        end
                    end
                end
            end else if (s_r.phase == PH_IDLE) begin
                // Ignored mid-session so live paths never see a change
                if (address == OFF_PIC) begin
                    s_nxt.pic = writedata;
                end else if (address >= OFF_PATH_BASE
                             && address[1:0] == 2'h0
                             && blk < 4'(NUM_PATHS)) begin
                    s_nxt.preg[blk[1:0]][address[3:2]] = writedata;
                end
            end
        end
        if (take) begin
            if (pix_eof) begin
                s_nxt.x = '0;
                s_nxt.y = '0;
                s_nxt.frames = s_r.frames + 16'h1;
                // One handle per enabled path, in hardware return only
                s_nxt.hv = s_r.hw;
                for (int p = 0; p < NUM_PATHS; p++) begin
                    s_nxt.hmask[p] = s_r.cur[p].en;
                    s_nxt.h10[p] = s_r.cur[p].en && s_r.src10
                                   && !s_r.cur[p].reduce;
                end
            end else if (pix_eol) begin
                s_nxt.x = '0;
                s_nxt.y = s_r.y + 14'h1;
            end else begin
                s_nxt.x = s_r.x + 14'h1;
            end
        end
        if (sei_in_valid && sei_ok(sei_in_type)) begin
            s_nxt.sv = 1'b1;
            s_nxt.stype = sei_in_type;
            s_nxt.sdata = sei_in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    path0_on_a: assert property (@(posedge clock) disable iff (!nrst)
        s_r.phase == PH_ACTIVE |-> s_r.cur[0].en)
        else $error("path 0 not enabled in session");
    sw_paths_off_a: assert property (@(posedge clock) disable iff (!nrst)
        s_r.phase == PH_ACTIVE && !s_r.hw |->
        !s_r.cur[1].en && !s_r.cur[2].en && !chip_valid[0])
        else $error("extra path live in software return");
    dim_range_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(s_r.phase == PH_ACTIVE) |->
        pw <= MAX_DIM && ph <= MAX_DIM
        && pw >= (s_r.jpeg ? MIN_DIM_JPEG : MIN_DIM))
        else $error("session started with bad size");
    jpeg_depth_a: assert property (@(posedge clock) disable iff (!nrst)
        s_r.phase == PH_ACTIVE && s_r.jpeg |-> !s_r.src10)
        else $error("10-bit JPEG session");
    cfg_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        s_r.phase == PH_ACTIVE && $past(s_r.phase) == PH_ACTIVE
        |-> $stable(s_r.cur))
        else $error("path settings changed mid-session");
    crop_fit_a: assert property (@(posedge clock) disable iff (!nrst)
        s_r.phase == PH_ACTIVE |->
        {1'b0, s_r.cur[1].tx} + {1'b0, s_r.cur[1].tw} <= {1'b0, pw}
        && s_r.cur[1].rw <= s_r.cur[1].tw)
        else $error("crop window outside picture");
    handle_out_a: assert property (@(posedge clock) disable iff (!nrst)
        take && pix_eof && s_r.hw |=>
        handle_valid && handle_mask[0]
        && handle_seq == $past(s_r.frames) + 16'h1)
        else $error("frame handle missing");
    sei_pass_a: assert property (@(posedge clock) disable iff (!nrst)
        sei_in_valid && sei_ok(sei_in_type) |=>
        sei_out_valid && sei_out_type == $past(sei_in_type))
        else $error("supported metadata dropped");
    bus_answer_a: assert property (@(posedge clock) disable iff (!nrst)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// ==== vdp_sink.sv ====
// Downstream consumer model: host side and on-chip side.
// Assumes outputs hold while ready is low.
`timescale 1ns/1ps
`default_nettype none
module vdp_sink
    import vdp_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    stall,
    input  wire logic                    host_valid,
    output var  logic                    host_ready,
    input  wire logic [SW-1:0]           host_data,
    input  wire logic [NUM_PATHS-1:0]    chip_valid,
    output var  logic [NUM_PATHS-1:0]    chip_ready,
    input  wire logic [NUM_PATHS*SW-1:0] chip_data,
    output var  logic [SW-1:0]           host_last,
    output var  logic [SW-1:0]           chip1_last
);
    logic tog_r = 1'b0;
    // Stall drops ready every other cycle so outputs must hold
    always_ff @(posedge clock) begin
        tog_r <= ~tog_r;
        if (host_valid && host_ready)
            host_last <= host_data;
        if (chip_valid[1] && chip_ready[1])
            chip1_last <= chip_data[SW+:SW];
    end
    assign host_ready = !stall || tog_r;
    assign chip_ready = {NUM_PATHS{host_ready}};
endmodule
`default_nettype wire

// ==== video_decode_post_processor_bench.sv ====
// Bench of the post-processor: bus tasks, pixel feed, metadata.
// Assumes the one-cycle bus answer of the top module.
`timescale 1ns/1ps
`default_nettype none
module video_decode_post_processor_bench;
    import vdp_pkg::*;
    logic clock = 0, nrst = 0, read = 0, write = 0, stall = 0;
    logic [7:0] address = 8'h00, sei_in_type = 8'h00, sei_out_type;
    logic [31:0] writedata = 32'h0, readdata, rd, sei_in_data = 32'h0;
    logic [31:0] sei_out_data;
    logic waitrequest, pix_valid = 0, pix_ready, pix_eol = 0, pix_eof = 0;
    logic host_valid, host_ready, handle_valid, sei_in_valid = 0;
    logic sei_out_valid;
    logic [SW-1:0] pix_data = 10'h000, host_data, host_last, chip1_last;
    logic [NUM_PATHS-1:0] chip_valid, chip_ready, handle_mask, handle_10bit;
    logic [NUM_PATHS*SW-1:0] chip_data;
    logic [15:0] handle_seq;
    logic [2:0] cores_used;
    logic [4*DW-1:0] hdr_trim = '0;
    logic [7:0] sei_t [7] = '{8'h00, 8'h01, 8'h04, 8'h89, 8'h90, 8'h93,
                              8'h05};
    int err_count = 0, compares = 0, cyc = 0;
    vdp_top dut (.clock, .nrst, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .hdr_trim, .pix_valid, .pix_ready,
        .pix_data, .pix_eol, .pix_eof, .host_valid, .host_ready,
        .host_data, .chip_valid, .chip_ready, .chip_data, .handle_valid,
        .handle_mask, .handle_10bit, .handle_seq, .cores_used,
        .sei_in_valid, .sei_in_type, .sei_in_data, .sei_out_valid,
        .sei_out_type, .sei_out_data);
    vdp_sink sink (.clock, .stall, .host_valid, .host_ready, .host_data,
        .chip_valid, .chip_ready, .chip_data, .host_last, .chip1_last);
    always #12.5 clock = ~clock;
    always @(posedge clock) if (++cyc == 20000) begin
        err_count++;
        conclude();
    end
    task automatic conclude;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clock); while (waitrequest);
        rd = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic pix(input logic [SW-1:0] d, input logic eof);
        @(posedge clock);
        pix_valid <= 1;
        pix_data <= d;
        pix_eof <= eof;
        do @(posedge clock); while (!pix_ready);
        pix_valid <= 0;
        pix_eof <= 0;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1;
        bus(0, OFF_STATUS, 0); check(rd, 0);
        bus(0, 8'h10, 0); check(rd, 0);
        bus(0, 8'hF0, 0); check(rd, 0);
        check(cores_used, CORES_SINGLE);
        bus(1, OFF_PIC, 32'h0064_0064);
        bus(1, OFF_CTRL, 32'h01); bus(0, OFF_STATUS, 0);
        check(rd[1:0], 2'h2);
        bus(1, OFF_CTRL, 32'h31); bus(0, OFF_STATUS, 0);
        check({rd[2], rd[0]}, 2'h2);
        bus(1, OFF_PIC, 32'h0030_0030);
        bus(1, OFF_CTRL, 32'h11); bus(0, OFF_STATUS, 0);
        check(rd[0], 1'b1);
        bus(1, OFF_CTRL, 32'h02);
        // Even sizes, full-picture crop, no resize
        bus(1, OFF_PIC, 32'h0090_0090);
        bus(1, 8'h10, 32'h08);
        bus(1, 8'h20, 32'h1D);
        bus(1, OFF_CTRL, 32'h21);
        bus(1, 8'h10, 32'h00); bus(0, 8'h10, 0); check(rd, 32'h08);
        pix(10'h3FF, 0);
        repeat (2) @(posedge clock);
        check(host_last, 10'h0FF);
        check(chip_valid, 0);
        pix(10'h2A5, 1);
        bus(1, OFF_CTRL, 32'h02);
        stall <= 1;
        // Path 0 halves its width, path 1 crops from x 1
        bus(1, 8'h1C, 32'h0000_0048);
        bus(1, 8'h24, 32'h0030_0030);
        bus(1, 8'h28, 32'h0000_0001);
        bus(1, OFF_CTRL, 32'h2D);
        @(posedge clock);
        check(cores_used, CORES_GANG);
        pix(10'h3FF, 0);
        @(posedge clock);
        check(chip_valid, 3'h0);
        pix(10'h155, 1);
        repeat (8) begin
            @(posedge clock);
            if (handle_valid) break;
        end
        check(handle_mask, 3'h3);
        check(handle_10bit, 3'h2);
        check(handle_seq, 16'h2);
        repeat (3) @(posedge clock);
        check(chip1_last, 10'h155);
        foreach (sei_t[i]) begin
            @(posedge clock);
            sei_in_valid <= 1;
            sei_in_type <= sei_t[i];
            sei_in_data <= 32'hC0DE_0000 + i;
            @(posedge clock);
            sei_in_valid <= 0;
            @(posedge clock);
            check(sei_out_valid, i < 6);
            check(sei_out_type, sei_t[i < 6 ? i : 5]);
            check(sei_out_data, 32'hC0DE_0000 + (i < 6 ? i : 5));
        end
        conclude();
    end
endmodule
`default_nettype wire
